//--- core/pimoc_regs.svh
// register offsets, field positions and reset values of one port
// assumes address bits 15:12 carry the port number
`ifndef PIMOC_REGS_SVH
`define PIMOC_REGS_SVH

// offsets inside the port window
`define PIMOC_OFS_ISTAT 12'h01B
`define PIMOC_OFS_MASK  12'h01F
`define PIMOC_OFS_OPCTL 12'h020
`define PIMOC_OFS_EVST  12'h0F0
`define PIMOC_OFS_EVCLR 12'h0F1
`define PIMOC_OFS_EVEN  12'h0F2

// writable bits per register
`define PIMOC_MASK_WMASK  8'h07
`define PIMOC_OPCTL_WMASK 8'hC7
`define PIMOC_EV_WMASK    3'h7

// reset values
`define PIMOC_MASK_RST  8'h00
`define PIMOC_OPCTL_RST 8'h00
`define PIMOC_EV_RST    3'h0
`define PIMOC_ZERO8     8'h00

// mask and status bit positions
`define PIMOC_B_ACL 0
`define PIMOC_B_PHY 1
`define PIMOC_B_PTP 2

// control bit positions
`define PIMOC_B_LLB 7
`define PIMOC_B_RLB 6
`define PIMOC_B_TT  2
`define PIMOC_B_QHI 1
`define PIMOC_B_QLO 0

// event status bit positions
`define PIMOC_E_ACL  0
`define PIMOC_E_QRSV 1
`define PIMOC_E_IRQ  2

`endif

//--- core/pimoc_pkg.sv
// types shared by the port mask and control logic
// assumes the constants header sits beside it
//
// How it works
// - mask bit 0 enables its source, 1 disables; all reset to 0
// - timestamp and PHY mask bits act only on ports with a PHY
// - access list mask bit 0 acts on every port
// - access list status clears when software toggles its mask bit
// - status shows sources; each reaches the port irq only if unmasked
// - control bit 7 loops fabric egress data back inside the MAC
// - control bit 6 sends line receive data back out the same port
// - PHY port loops rx pair to tx; MII port loops txd to rxd
// - control bit 2 turns on tail tagging for this host port
// - bits 1:0 pick one, two or four queues; 11 reserved
// - single queue ignores priority; both registers reset to 0
package pimoc_pkg;

    typedef enum logic [1:0] {
        PIMOC_Q_ONE  = 2'b00,
        PIMOC_Q_TWO  = 2'b01,
        PIMOC_Q_FOUR = 2'b10,
        PIMOC_Q_RSV  = 2'b11
    } pimoc_qmode_t;

    typedef struct packed {
        logic [7:0] mask_r;
        logic [7:0] opctl_r;
        logic       acl_st_r;
        logic [1:0] src_r;
        logic [2:0] evst_r;
        logic [2:0] even_r;
        logic [7:0] rdata_r;
        logic       irq_prev_r;
        logic [1:0] qsel_r;
        logic       qsel_vld_r;
    } pimoc_state_t;

endpackage

//--- core/pimoc_lpbk.sv
// loopback steering between fabric and line for one port
// assumes one byte per cycle on each side, valid marks data
`timescale 1ns/1ps
module pimoc_lpbk #(
    parameter int DW = 8
) (
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic          llb_en,
    input  wire logic          rlb_en,
    input  wire logic [DW-1:0] fab_tx_data,
    input  wire logic          fab_tx_vld,
    input  wire logic [DW-1:0] line_rx_data,
    input  wire logic          line_rx_vld,
    output logic      [DW-1:0] fab_rx_data,
    output logic               fab_rx_vld,
    output logic      [DW-1:0] line_tx_data,
    output logic               line_tx_vld
);

    typedef struct packed {
        logic [DW-1:0] fab_d_r;
        logic          fab_v_r;
        logic [DW-1:0] line_d_r;
        logic          line_v_r;
    } pimoc_lpbk_t;

    pimoc_lpbk_t st;
    pimoc_lpbk_t st_nxt;

    always_comb begin
        st_nxt = st;
        if (llb_en) begin
            st_nxt.fab_d_r = fab_tx_data;
            st_nxt.fab_v_r = fab_tx_vld;
        end else if (rlb_en) begin
            st_nxt.fab_d_r = '0;
            st_nxt.fab_v_r = 1'b0;
        end else begin
            st_nxt.fab_d_r = line_rx_data;
            st_nxt.fab_v_r = line_rx_vld;
        end
        if (rlb_en) begin
            st_nxt.line_d_r = line_rx_data;
            st_nxt.line_v_r = line_rx_vld;
        end else if (llb_en) begin
            st_nxt.line_d_r = '0;
            st_nxt.line_v_r = 1'b0;
        end else begin
            st_nxt.line_d_r = fab_tx_data;
            st_nxt.line_v_r = fab_tx_vld;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= st_nxt;
        end
    end

    assign fab_rx_data  = st.fab_d_r;
    assign fab_rx_vld   = st.fab_v_r;
    assign line_tx_data = st.line_d_r;
    assign line_tx_vld  = st.line_v_r;

    chk_local_loop: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        llb_en |=> fab_rx_vld == $past(fab_tx_vld)
            && fab_rx_data == $past(fab_tx_data))
        else $error("local loopback lost fabric data");

    chk_remote_loop: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        rlb_en && !llb_en |=> line_tx_vld == $past(line_rx_vld)
            && line_tx_data == $past(line_rx_data) && !fab_rx_vld)
        else $error("remote loopback path wrong");

endmodule

//--- core/pimoc_port_ctl.sv
// port interrupt mask and operation control registers of one port
// assumes a one-cycle register port and level interrupt sources
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "pimoc_regs.svh"
module pimoc_port_ctl #(
    parameter logic [3:0] PORT_NUM = 4'h1,
    parameter bit         HAS_PHY  = 1'b1,
    parameter int         DW       = 8
) (
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic [15:0]   reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [7:0]    reg_rdata,
    input  wire logic          ptp_src,
    input  wire logic          phy_src,
    input  wire logic          acl_evt,
    output logic               port_irq,
    output logic               ev_irq,
    input  wire logic          frm_vld,
    input  wire logic [2:0]    frm_prio,
    output logic      [1:0]    frm_queue,
    output logic               frm_queue_vld,
    output logic      [1:0]    queue_mode,
    output logic               tail_tag_en,
    input  wire logic [DW-1:0] fab_tx_data,
    input  wire logic          fab_tx_vld,
    input  wire logic [DW-1:0] line_rx_data,
    input  wire logic          line_rx_vld,
    output logic      [DW-1:0] fab_rx_data,
    output logic               fab_rx_vld,
    output logic      [DW-1:0] line_tx_data,
    output logic               line_tx_vld
);

    pimoc_pkg::pimoc_state_t st;
    pimoc_pkg::pimoc_state_t st_nxt;

    logic       wr_mask;
    logic       wr_opctl;
    logic       acl_toggle;
    logic [2:0] src_vec;
    logic [2:0] ev_set;
    logic       irq_now;

    // address decode for this port window
    function automatic logic hit(
        input logic [15:0] a,
        input logic [11:0] ofs
    );
        hit = (a[15:12] == PORT_NUM) && (a[11:0] == ofs);
    endfunction

    // queue chosen from frame priority
    function automatic logic [1:0] qsel(
        input logic [1:0] mode,
        input logic [2:0] prio
    );
        unique case (mode)
            pimoc_pkg::PIMOC_Q_TWO: begin
                qsel = {1'b0, prio[2]};
            end
            pimoc_pkg::PIMOC_Q_FOUR: begin
                qsel = prio[2:1];
            end
            pimoc_pkg::PIMOC_Q_ONE,
            pimoc_pkg::PIMOC_Q_RSV: begin
                qsel = 2'h0;
            end
        endcase
    endfunction

    assign wr_mask  = reg_wr && hit(reg_addr, `PIMOC_OFS_MASK);
    assign wr_opctl = reg_wr && hit(reg_addr, `PIMOC_OFS_OPCTL);

    assign acl_toggle = wr_mask && (reg_wdata[`PIMOC_B_ACL]
        != st.mask_r[`PIMOC_B_ACL]);

    assign src_vec = {st.src_r, st.acl_st_r};

    assign irq_now = |(src_vec & ~st.mask_r[2:0]);

    assign ev_set[`PIMOC_E_ACL]  = acl_evt;
    assign ev_set[`PIMOC_E_QRSV] = wr_opctl
        && (reg_wdata[1:0] == pimoc_pkg::PIMOC_Q_RSV);
    assign ev_set[`PIMOC_E_IRQ]  = irq_now && !st.irq_prev_r;

    always_comb begin
        st_nxt = st;
        st_nxt.rdata_r = `PIMOC_ZERO8;
        st_nxt.irq_prev_r = irq_now;

        // phy and timestamp gated off without phy
        st_nxt.src_r = HAS_PHY ? {ptp_src, phy_src} : 2'h0;

        // access list status on every port
        if (acl_evt) begin
            st_nxt.acl_st_r = 1'b1;
        end else if (acl_toggle) begin
            st_nxt.acl_st_r = 1'b0;
        end

        if (wr_mask) begin
            st_nxt.mask_r = reg_wdata & `PIMOC_MASK_WMASK;
        end
        if (wr_opctl) begin
            st_nxt.opctl_r = reg_wdata & `PIMOC_OPCTL_WMASK;
        end
        if (reg_wr && hit(reg_addr, `PIMOC_OFS_EVEN)) begin
            st_nxt.even_r = reg_wdata[2:0] & `PIMOC_EV_WMASK;
        end

        // sticky events, set wins over clear
        st_nxt.evst_r = st.evst_r | ev_set;
        if (reg_wr && hit(reg_addr, `PIMOC_OFS_EVCLR)) begin
            st_nxt.evst_r = (st.evst_r & ~reg_wdata[2:0]) | ev_set;
        end

        st_nxt.qsel_vld_r = frm_vld;
        if (frm_vld) begin
            st_nxt.qsel_r = qsel(st.opctl_r[1:0], frm_prio);
        end

        // read data one cycle after strobe
        if (reg_rd) begin
            if (hit(reg_addr, `PIMOC_OFS_ISTAT)) begin
                st_nxt.rdata_r = {5'h00, src_vec};
            end else if (hit(reg_addr, `PIMOC_OFS_MASK)) begin
                st_nxt.rdata_r = st.mask_r;
            end else if (hit(reg_addr, `PIMOC_OFS_OPCTL)) begin
                st_nxt.rdata_r = st.opctl_r;
            end else if (hit(reg_addr, `PIMOC_OFS_EVST)) begin
                st_nxt.rdata_r = {5'h00, st.evst_r};
            end else if (hit(reg_addr, `PIMOC_OFS_EVEN)) begin
                st_nxt.rdata_r = {5'h00, st.even_r};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.mask_r <= `PIMOC_MASK_RST;
            st.opctl_r <= `PIMOC_OPCTL_RST;
            st.evst_r <= `PIMOC_EV_RST;
            st.even_r <= `PIMOC_EV_RST;
        end else begin
            st <= st_nxt;
        end
    end

    assign reg_rdata     = st.rdata_r;
    assign port_irq      = st.irq_prev_r;
    assign ev_irq        = |(st.evst_r & st.even_r);
    assign frm_queue     = st.qsel_r;
    assign frm_queue_vld = st.qsel_vld_r;
    assign queue_mode    = st.opctl_r[`PIMOC_B_QHI:`PIMOC_B_QLO];
    assign tail_tag_en   = st.opctl_r[`PIMOC_B_TT];

    pimoc_lpbk #(
        .DW (DW)
    ) u_lpbk (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .llb_en       (st.opctl_r[`PIMOC_B_LLB]),
        .rlb_en       (st.opctl_r[`PIMOC_B_RLB]),
        .fab_tx_data  (fab_tx_data),
        .fab_tx_vld   (fab_tx_vld),
        .line_rx_data (line_rx_data),
        .line_rx_vld  (line_rx_vld),
        .fab_rx_data  (fab_rx_data),
        .fab_rx_vld   (fab_rx_vld),
        .line_tx_data (line_tx_data),
        .line_tx_vld  (line_tx_vld)
    );

    // acl status set with no new acl event, and mask toggled in the same cycle
    sequence s_acl_held;
        st.acl_st_r && !acl_evt;
    endsequence

    sequence s_acl_toggle;
        wr_mask && acl_toggle;
    endsequence

    chk_acl_clear: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        s_acl_held ##0 s_acl_toggle |=> !st.acl_st_r
            ##1 port_irq == $past(|(st.src_r
            & ~st.mask_r[`PIMOC_B_PTP:`PIMOC_B_PHY])))
        else $error("access list status not cleared by toggle");

    chk_acl_raise: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        acl_evt && !st.mask_r[`PIMOC_B_ACL] && !wr_mask
            |=> ##1 port_irq)
        else $error("unmasked access list event gave no irq");

    chk_mask_gate: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (&st.mask_r[2:0]) && !wr_mask |=> !port_irq)
        else $error("irq with every source masked");

    chk_nophy_gate: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !HAS_PHY && reg_rd && hit(reg_addr, `PIMOC_OFS_ISTAT)
            |=> reg_rdata[2:1] == 2'h0)
        else $error("phy source visible on port without phy");

    chk_status_read: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        reg_rd && hit(reg_addr, `PIMOC_OFS_ISTAT)
            |=> reg_rdata[`PIMOC_B_ACL] == $past(st.acl_st_r))
        else $error("status read does not show access list state");

    chk_tail_tag: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        wr_opctl |=> tail_tag_en == $past(reg_wdata[`PIMOC_B_TT]))
        else $error("tail tag enable did not follow write");

    chk_queue_four: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        frm_vld && queue_mode == pimoc_pkg::PIMOC_Q_FOUR
            |=> frm_queue_vld && frm_queue == $past(frm_prio[2:1]))
        else $error("four queue split wrong");

    chk_single_q: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        frm_vld && queue_mode == pimoc_pkg::PIMOC_Q_ONE
            |=> frm_queue == 2'h0)
        else $error("single queue mode used priority");

    chk_rsvd_zero: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        reg_rd && hit(reg_addr, `PIMOC_OFS_OPCTL)
            |=> reg_rdata[5:3] == 3'h0)
        else $error("reserved control bits read nonzero");

    sequence s_frm_two;
        frm_vld && queue_mode == pimoc_pkg::PIMOC_Q_TWO;
    endsequence

    sequence s_frm_rsv;
        frm_vld && queue_mode == pimoc_pkg::PIMOC_Q_RSV;
    endsequence

    chk_queue_two: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        s_frm_two |=> frm_queue_vld
            && frm_queue == {1'b0, $past(frm_prio[2])})
        else $error("two queue split wrong");

    chk_queue_rsvd: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        s_frm_rsv |=> frm_queue_vld && frm_queue == 2'h0)
        else $error("reserved queue code used priority");

    chk_queue_mode: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        wr_opctl |=> queue_mode
            == $past(reg_wdata[`PIMOC_B_QHI:`PIMOC_B_QLO]))
        else $error("queue mode did not follow write");

    chk_qrsv_event: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        wr_opctl && reg_wdata[`PIMOC_B_QHI:`PIMOC_B_QLO]
            == pimoc_pkg::PIMOC_Q_RSV |=> st.evst_r[`PIMOC_E_QRSV])
        else $error("reserved queue code raised no event");

    chk_acl_set_wins: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        acl_evt |=> st.acl_st_r)
        else $error("access list event not latched");

    chk_acl_sticky: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        st.acl_st_r && !acl_toggle |=> st.acl_st_r)
        else $error("access list status dropped without toggle");

    chk_irq_source: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        st.acl_st_r && !st.mask_r[`PIMOC_B_ACL] |=> port_irq)
        else $error("pending access list status gave no irq");

    chk_phy_raise: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        HAS_PHY && |(st.src_r & ~st.mask_r[`PIMOC_B_PTP:`PIMOC_B_PHY])
            |=> port_irq)
        else $error("unmasked phy side source gave no irq");

    chk_nophy_quiet: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !HAS_PHY && !st.acl_st_r |=> !port_irq)
        else $error("irq on port without phy and no access list");

    chk_mask_write: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        wr_mask |=> st.mask_r == ($past(reg_wdata) & `PIMOC_MASK_WMASK))
        else $error("mask register did not take write");

    chk_mask_rsvd: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        reg_rd && hit(reg_addr, `PIMOC_OFS_MASK)
            |=> (reg_rdata & ~`PIMOC_MASK_WMASK) == `PIMOC_ZERO8)
        else $error("reserved mask bits read nonzero");

    chk_rd_idle: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !reg_rd |=> reg_rdata == `PIMOC_ZERO8)
        else $error("read data not zero outside a read");

    chk_other_port: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr[15:12] != PORT_NUM
            |=> $stable(st.mask_r) && $stable(st.opctl_r))
        else $error("write to another port changed a register");

    chk_ev_set_wins: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        ev_set != 3'h0
            |=> (st.evst_r & $past(ev_set)) == $past(ev_set))
        else $error("event lost its status bit");

    chk_ev_clear: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        reg_wr && hit(reg_addr, `PIMOC_OFS_EVCLR) && ev_set == 3'h0
            |=> (st.evst_r & $past(reg_wdata[2:0])) == 3'h0)
        else $error("event clear left a bit set");

    chk_normal_path: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !st.opctl_r[`PIMOC_B_LLB] && !st.opctl_r[`PIMOC_B_RLB]
            |=> fab_rx_vld == $past(line_rx_vld)
            && line_tx_vld == $past(fab_tx_vld))
        else $error("normal path not passing data");

endmodule

//--- tb/pimoc_port_ctl_tb_top.sv
// self-checking bench for the port mask and control registers
// assumes one port instance at port number 1 with a PHY and one at port number 3 without
`timescale 1ns/1ps
module pimoc_port_ctl_tb_top;
    logic        sys_clk       = 1'b0;
    logic        rstn          = 1'b0;
    logic [15:0] reg_addr      = 16'h0000;
    logic [7:0]  reg_wdata     = 8'h00;
    logic        reg_wr        = 1'b0;
    logic        reg_rd        = 1'b0;
    logic        ptp_src       = 1'b0;
    logic        phy_src       = 1'b0;
    logic        acl_evt       = 1'b0;
    logic        frm_vld       = 1'b0;
    logic [2:0]  frm_prio      = 3'h0;
    logic [7:0]  fab_tx_data   = 8'ha5;
    logic        fab_tx_vld    = 1'b0;
    logic [7:0]  line_rx_data  = 8'h3c;
    logic        line_rx_vld   = 1'b0;
    logic [7:0]  reg_rdata;
    logic        port_irq;
    logic        ev_irq;
    logic [1:0]  frm_queue;
    logic        frm_queue_vld;
    logic [1:0]  queue_mode;
    logic        tail_tag_en;
    logic [7:0]  fab_rx_data;
    logic        fab_rx_vld;
    logic [7:0]  line_tx_data;
    logic        line_tx_vld;
    logic [7:0]  np_rdata;
    logic        np_irq;
    int          fail_count    = 0;
    int          num_checks    = 0;

    pimoc_port_ctl #(
        .PORT_NUM (4'h1),
        .HAS_PHY  (1'b1),
        .DW       (8)
    ) dut_u (
        .sys_clk       (sys_clk),
        .rstn          (rstn),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .ptp_src       (ptp_src),
        .phy_src       (phy_src),
        .acl_evt       (acl_evt),
        .port_irq      (port_irq),
        .ev_irq        (ev_irq),
        .frm_vld       (frm_vld),
        .frm_prio      (frm_prio),
        .frm_queue     (frm_queue),
        .frm_queue_vld (frm_queue_vld),
        .queue_mode    (queue_mode),
        .tail_tag_en   (tail_tag_en),
        .fab_tx_data   (fab_tx_data),
        .fab_tx_vld    (fab_tx_vld),
        .line_rx_data  (line_rx_data),
        .line_rx_vld   (line_rx_vld),
        .fab_rx_data   (fab_rx_data),
        .fab_rx_vld    (fab_rx_vld),
        .line_tx_data  (line_tx_data),
        .line_tx_vld   (line_tx_vld)
    );

    // second port without a phy, on port number 3
    pimoc_port_ctl #(
        .PORT_NUM (4'h3),
        .HAS_PHY  (1'b0),
        .DW       (8)
    ) nophy_u (
        .sys_clk       (sys_clk),
        .rstn          (rstn),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (np_rdata),
        .ptp_src       (ptp_src),
        .phy_src       (phy_src),
        .acl_evt       (acl_evt),
        .port_irq      (np_irq),
        .ev_irq        (),
        .frm_vld       (frm_vld),
        .frm_prio      (frm_prio),
        .frm_queue     (),
        .frm_queue_vld (),
        .queue_mode    (),
        .tail_tag_en   (),
        .fab_tx_data   (fab_tx_data),
        .fab_tx_vld    (fab_tx_vld),
        .line_rx_data  (line_rx_data),
        .line_rx_vld   (line_rx_vld),
        .fab_rx_data   (),
        .fab_rx_vld    (),
        .line_tx_data  (),
        .line_tx_vld   ()
    );

    always #10 sys_clk = ~sys_clk;

    task test_done;
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata | np_rdata});
    endtask

    task pulse_acl;
        @(posedge sys_clk);
        acl_evt <= 1'b1;
        @(posedge sys_clk);
        acl_evt <= 1'b0;
    endtask

    task qchk(input logic [2:0] p, input logic [1:0] e);
        @(posedge sys_clk);
        frm_vld  <= 1'b1;
        frm_prio <= p;
        @(posedge sys_clk);
        frm_vld <= 1'b0;
        @(negedge sys_clk);
        chk("frm_queue", {13'h0000, 1'b1, e},
            {13'h0000, frm_queue_vld, frm_queue});
    endtask

    task lb(input logic [7:0] c, input logic [8:0] fr, input logic [8:0] lt);
        wr(16'h1020, c);
        @(posedge sys_clk);
        fab_tx_vld  <= 1'b1;
        line_rx_vld <= 1'b1;
        @(posedge sys_clk);
        fab_tx_vld  <= 1'b0;
        line_rx_vld <= 1'b0;
        @(negedge sys_clk);
        chk("fab_rx", {7'h00, fr}, {7'h00, fab_rx_vld, fab_rx_data});
        chk("line_tx", {7'h00, lt}, {7'h00, line_tx_vld, line_tx_data});
    endtask

    function automatic logic [1:0] qexp(input int m, input int p);
        case (m)
            1: qexp = {1'b0, p[2]};
            2: qexp = p[2:1];
            default: qexp = 2'b00;
        endcase
    endfunction

    initial begin
        #100000;
        fail_count++;
        test_done;
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(16'h101f, 8'h00);
        rd(16'h1020, 8'h00);
        chk("port_irq", 16'h0000, {15'h0000, port_irq});
        wr(16'h101f, 8'hff);
        rd(16'h101f, 8'h07);
        wr(16'h1020, 8'hff);
        rd(16'h1020, 8'hc7);
        @(negedge sys_clk);
        chk("reg_rdata", 16'h0000, {8'h00, reg_rdata});
        wr(16'h201f, 8'h00);
        rd(16'h101f, 8'h07);
        rd(16'h201f, 8'h00);
        rd(16'h1050, 8'h00);
        wr(16'h101f, 8'h00);
        wr(16'h1020, 8'h00);
        // source masking
        @(posedge sys_clk);
        ptp_src <= 1'b1;
        settle(3);
        chk("port_irq", 16'h0001, {15'h0000, port_irq});
        chk("np_irq", 16'h0000, {15'h0000, np_irq});
        rd(16'h101b, 8'h04);
        rd(16'h301b, 8'h00);
        wr(16'h101f, 8'h04);
        settle(3);
        chk("port_irq", 16'h0000, {15'h0000, port_irq});
        @(posedge sys_clk);
        ptp_src <= 1'b0;
        phy_src <= 1'b1;
        settle(3);
        chk("port_irq", 16'h0001, {15'h0000, port_irq});
        chk("np_irq", 16'h0000, {15'h0000, np_irq});
        wr(16'h101f, 8'h06);
        settle(3);
        chk("port_irq", 16'h0000, {15'h0000, port_irq});
        rd(16'h101b, 8'h02);
        @(posedge sys_clk);
        phy_src <= 1'b0;
        wr(16'h101f, 8'h00);
        // sticky access list status
        wr(16'h10f1, 8'h07);
        wr(16'h10f2, 8'h01);
        pulse_acl;
        settle(2);
        chk("port_irq", 16'h0001, {15'h0000, port_irq});
        chk("np_irq", 16'h0001, {15'h0000, np_irq});
        chk("ev_irq", 16'h0001, {15'h0000, ev_irq});
        rd(16'h301b, 8'h01);
        rd(16'h101b, 8'h01);
        rd(16'h101b, 8'h01);
        rd(16'h10f0, 8'h05);
        wr(16'h10f1, 8'h01);
        settle(0);
        chk("ev_irq", 16'h0000, {15'h0000, ev_irq});
        wr(16'h101f, 8'h01);
        rd(16'h101b, 8'h00);
        chk("port_irq", 16'h0000, {15'h0000, port_irq});
        pulse_acl;
        settle(2);
        rd(16'h101b, 8'h01);
        chk("port_irq", 16'h0000, {15'h0000, port_irq});
        wr(16'h101f, 8'h00);
        rd(16'h101b, 8'h00);
        // queue split for every code and priority
        for (int m = 0; m < 4; m++) begin
            wr(16'h1020, {6'h00, m[1:0]});
            settle(0);
            chk("queue_mode", m[15:0], {14'h0000, queue_mode});
            for (int p = 0; p < 8; p++) begin
                qchk(p[2:0], qexp(m, p));
            end
        end
        wr(16'h10f1, 8'h07);
        wr(16'h1020, 8'h03);
        rd(16'h10f0, 8'h02);
        wr(16'h1020, 8'h04);
        settle(0);
        chk("tail_tag_en", 16'h0001, {15'h0000, tail_tag_en});
        wr(16'h1020, 8'h00);
        settle(0);
        chk("tail_tag_en", 16'h0000, {15'h0000, tail_tag_en});
        // loopback paths
        lb(8'h00, 9'h13c, 9'h1a5);
        lb(8'h80, 9'h1a5, 9'h000);
        lb(8'h40, 9'h000, 9'h13c);
        lb(8'hc0, 9'h1a5, 9'h13c);
        // reset in mid run returns both registers to zero
        wr(16'h1020, 8'h06);
        wr(16'h101f, 8'h07);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(16'h101f, 8'h00);
        rd(16'h1020, 8'h00);
        test_done;
    end
endmodule
